/* shared/isel_defines.svh */
`ifndef ISEL_DEFINES_SVH
`define ISEL_DEFINES_SVH
`define ISEL_ADDR_EXTRA   8'ha7
`define ISEL_ADDR_PRIMARY 8'ha8
`define ISEL_RST_EXTRA    8'h00
`define ISEL_RST_PRIMARY  8'h00
`define ISEL_RD_IDLE      8'h00
`define ISEL_IEA_WMASK    8'hf3
`define ISEL_IE_GLOBAL    7
`define ISEL_IE_TRACE     6
`define ISEL_IE_T2        5
`define ISEL_IE_SER0      4
`define ISEL_IE_T1        3
`define ISEL_IE_EXT1      2
`define ISEL_IE_T0        1
`define ISEL_IE_EXT0      0
`define ISEL_IEA_ADC      7
`define ISEL_IEA_SPI      6
`define ISEL_IEA_PCA      5
`define ISEL_IEA_SER1     4
`define ISEL_IEA_I2C      1
`define ISEL_IEA_USB      0
`define ISEL_NSRC         12
`define ISEL_SRC_EXT0     0
`define ISEL_SRC_T0       1
`define ISEL_SRC_EXT1     2
`define ISEL_SRC_T1       3
`define ISEL_SRC_SER0     4
`define ISEL_SRC_T2       5
`define ISEL_SRC_SPI      6
`define ISEL_SRC_USB      7
`define ISEL_SRC_I2C      8
`define ISEL_SRC_ADC      9
`define ISEL_SRC_PCA      10
`define ISEL_SRC_SER1     11
`define ISEL_NFLG         12
`define ISEL_FLG_EXT0     0
`define ISEL_FLG_EXT1     1
`define ISEL_FLG_TF0      2
`define ISEL_FLG_TF1      3
`define ISEL_FLG_TF2      4
`define ISEL_FLG_EXF2     5
`define ISEL_FLG_I2C      6
`define ISEL_FLG_ADC      7
`define ISEL_FLG_USB_GLB  8
`define ISEL_FLG_USB_IN   9
`define ISEL_FLG_USB_OUT  10
`define ISEL_FLG_USB_NAK  11
`define ISEL_NPIN         3
`define ISEL_PIN_EXT0     0
`define ISEL_PIN_EXT1     1
`define ISEL_PIN_T2X      2
`define ISEL_PIN_IDLE     1'b1
`define ISEL_USB_EP       10
`define ISEL_PCA_NFLG     8
`define ISEL_SPI_NFLG     4
`define ISEL_I2C_NEVT     4
`define ISEL_USB_NGLB     4
`endif

/* shared/isel_pkg.sv */
`include "isel_defines.svh"
package isel_pkg;
	typedef logic [7:0] isel_byte_t;
	typedef logic [`ISEL_NSRC-1:0] isel_src_t;
	typedef struct packed {
		isel_byte_t primary;
		isel_byte_t extra;
		isel_byte_t rdata;
		isel_src_t  req;
	} isel_state_s;
endpackage

/* hw/isel_sync_fall.sv */
`timescale 1ns/1ns
`include "isel_defines.svh"
module isel_sync_fall #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] fall;
	} isel_sync_s;
	isel_sync_s st_q;
	isel_sync_s st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.fall = st_q.s3 & ~st_q.s2;
	end
	// Idle-high reset keeps release from faking a falling edge.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= {{(3*W){`ISEL_PIN_IDLE}}, {W{1'b0}}};
		end else begin
			st_q <= st_d;
		end
	end
	assign level = st_q.s2;
	assign fall = st_q.fall;
endmodule

/* hw/isel_flags.sv */
`timescale 1ns/1ns
module isel_flags #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] flag_q
);
	typedef struct packed {
		logic [W-1:0] flag;
	} isel_flags_s;
	isel_flags_s st_q;
	isel_flags_s st_d;
	// Set is applied last so a coinciding event survives the clear.
	always_comb begin
		st_d = st_q;
		st_d.flag = set | (st_q.flag & ~clr);
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign flag_q = st_q.flag;
endmodule

/* hw/isel_top.sv */
// Operation
// - External inputs select edge or level separately.
// - Edge mode: falling edge sets, service clears.
// - Level mode: low requests, service never clears.
// - Timer overflows set flags, not timer0 mode3.
// - Timer2 request ORs two software-cleared flags.
// - Trigger pin fall and overflow set timer2.
// - Each serial port ORs receive and transmit.
// - Peripheral port ORs its four status flags.
// - Two-wire events set one request flag.
// - Conversion end sets flag, software clears it.
// - Counter array ORs six matches, two overflows.
// - Bus reset, suspend, resume, packet end set.
// - Any empty endpoint transmit buffer sets flag.
// - Any full endpoint receive buffer sets flag.
// - Unready endpoint on inbound request sets flag.
// - Primary enable register resets zero, bits mapped.
// - Global enable zero blocks every request.
// - Extra enable register resets zero, bits mapped.
// - Requests are never remembered between polls.
`timescale 1ns/1ns
`include "isel_defines.svh"
module isel_top #(
	parameter int USB_EP = `ISEL_USB_EP
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic [7:0]                 sfr_wdata,
	input  wire logic                       sfr_rd,
	output logic      [7:0]                 sfr_rdata,
	input  wire logic                       ext_irq_pin_0,
	input  wire logic                       ext_irq_pin_1,
	input  wire logic                       timer2_trigger_pin,
	input  wire logic                       ext0_trigger_type,
	input  wire logic                       ext1_trigger_type,
	input  wire logic                       timer0_overflow,
	input  wire logic                       timer0_mode3,
	input  wire logic                       timer1_overflow,
	input  wire logic                       timer2_overflow,
	input  wire logic                       serial0_rx_flag,
	input  wire logic                       serial0_tx_flag,
	input  wire logic                       serial1_rx_flag,
	input  wire logic                       serial1_tx_flag,
	input  wire logic [`ISEL_SPI_NFLG-1:0]  spi_flags,
	input  wire logic [`ISEL_I2C_NEVT-1:0]  twowire_events,
	input  wire logic                       conversion_done,
	input  wire logic [`ISEL_PCA_NFLG-1:0]  pca_flags,
	input  wire logic [`ISEL_USB_NGLB-1:0]  usb_global_events,
	input  wire logic [USB_EP-1:0]          usb_in_empty,
	input  wire logic [USB_EP-1:0]          usb_out_full,
	input  wire logic [USB_EP-1:0]          usb_in_nak,
	input  wire logic [`ISEL_NSRC-1:0]      svc_enter,
	input  wire logic [`ISEL_NFLG-1:0]      flag_sw_clr,
	output logic      [`ISEL_NFLG-1:0]      flag_q,
	output logic      [`ISEL_NSRC-1:0]      irq_req,
	output logic      [7:0]                 primary_irq_enable,
	output logic      [7:0]                 extra_irq_enable
);
	isel_pkg::isel_state_s st_q;
	isel_pkg::isel_state_s st_d;

	logic [`ISEL_NPIN-1:0] pin_raw;
	logic [`ISEL_NPIN-1:0] pin_level;
	logic [`ISEL_NPIN-1:0] pin_fall;
	logic [`ISEL_NFLG-1:0] flag_set;
	logic [`ISEL_NFLG-1:0] flag_clr;
	logic [`ISEL_NFLG-1:0] flag_hw_clr;
	logic [`ISEL_NSRC-1:0] src_active;
	logic [`ISEL_NSRC-1:0] src_enable;

	logic ext0_low;
	logic ext1_low;
	logic ext0_edge_set;
	logic ext1_edge_set;
	logic ext0_level_set;
	logic ext1_level_set;
	logic ext0_level_clr;
	logic ext1_level_clr;
	logic ext0_svc_clr;
	logic ext1_svc_clr;
	logic tf0_set;
	logic tf1_set;
	logic tf2_set;
	logic exf2_set;
	logic i2c_set;
	logic adc_set;
	logic usb_glb_set;
	logic usb_in_set;
	logic usb_out_set;
	logic usb_nak_set;
	logic ser0_any;
	logic ser1_any;
	logic t2_any;
	logic spi_any;
	logic pca_any;
	logic usb_any;
	logic wr_primary;
	logic wr_extra;

	// One place decodes an SFR address, so a write and a read of a
	// register can never disagree about where it lives.
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return addr == target;
	endfunction

	// Byte read for one SFR address; unmapped addresses answer zero.
	function automatic logic [7:0] reg_read(
		input logic [7:0] addr,
		input logic [7:0] primary,
		input logic [7:0] extra
	);
		logic [7:0] val;
		val = `ISEL_RD_IDLE;
		if (addr_hit(addr, `ISEL_ADDR_PRIMARY)) begin
			val = primary;
		end else if (addr_hit(addr, `ISEL_ADDR_EXTRA)) begin
			val = extra & `ISEL_IEA_WMASK;
		end
		return val;
	endfunction

	// Maps each source to its own enable bit in the two registers.
	function automatic logic [`ISEL_NSRC-1:0] enable_map(
		input logic [7:0] primary,
		input logic [7:0] extra
	);
		logic [`ISEL_NSRC-1:0] en;
		en = '0;
		en[`ISEL_SRC_EXT0] = primary[`ISEL_IE_EXT0];
		en[`ISEL_SRC_T0] = primary[`ISEL_IE_T0];
		en[`ISEL_SRC_EXT1] = primary[`ISEL_IE_EXT1];
		en[`ISEL_SRC_T1] = primary[`ISEL_IE_T1];
		en[`ISEL_SRC_SER0] = primary[`ISEL_IE_SER0];
		en[`ISEL_SRC_T2] = primary[`ISEL_IE_T2];
		en[`ISEL_SRC_SPI] = extra[`ISEL_IEA_SPI];
		en[`ISEL_SRC_USB] = extra[`ISEL_IEA_USB];
		en[`ISEL_SRC_I2C] = extra[`ISEL_IEA_I2C];
		en[`ISEL_SRC_ADC] = extra[`ISEL_IEA_ADC];
		en[`ISEL_SRC_PCA] = extra[`ISEL_IEA_PCA];
		en[`ISEL_SRC_SER1] = extra[`ISEL_IEA_SER1];
		return en;
	endfunction

	// Flag terms of one external input: edge set, level set, level
	// clear and service clear. Level mode follows the pin, so a
	// service entry never drops a request that is still low.
	function automatic logic [3:0] ext_terms(
		input logic edge_mode,
		input logic fall,
		input logic low,
		input logic svc
	);
		logic [3:0] t;
		if (edge_mode) begin
			t = {fall, 1'b0, 1'b0, svc};
		end else begin
			t = {1'b0, low, ~low, 1'b0};
		end
		return t;
	endfunction

	// Gated request vector. It is rebuilt from live flags each cycle,
	// so nothing refused by an enable is kept for a later poll.
	function automatic logic [`ISEL_NSRC-1:0] gate_req(
		input logic [`ISEL_NSRC-1:0] active,
		input logic [`ISEL_NSRC-1:0] enable,
		input logic                  global_en
	);
		logic [`ISEL_NSRC-1:0] r;
		if (global_en) begin
			r = active & enable;
		end else begin
			r = '0;
		end
		return r;
	endfunction

	always_comb begin
		pin_raw = '0;
		pin_raw[`ISEL_PIN_EXT0] = ext_irq_pin_0;
		pin_raw[`ISEL_PIN_EXT1] = ext_irq_pin_1;
		pin_raw[`ISEL_PIN_T2X] = timer2_trigger_pin;
	end

	// Pins are asynchronous, so they are synchronised before any use.
	isel_sync_fall #(
		.W(`ISEL_NPIN)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     (pin_raw),
		.level   (pin_level),
		.fall    (pin_fall)
	);

	// External inputs: trigger type picks edge or level handling.
	assign ext0_low = ~pin_level[`ISEL_PIN_EXT0];
	assign ext1_low = ~pin_level[`ISEL_PIN_EXT1];
	assign {ext0_edge_set, ext0_level_set, ext0_level_clr, ext0_svc_clr} =
		ext_terms(ext0_trigger_type, pin_fall[`ISEL_PIN_EXT0],
		ext0_low, svc_enter[`ISEL_SRC_EXT0]);
	assign {ext1_edge_set, ext1_level_set, ext1_level_clr, ext1_svc_clr} =
		ext_terms(ext1_trigger_type, pin_fall[`ISEL_PIN_EXT1],
		ext1_low, svc_enter[`ISEL_SRC_EXT1]);

	// Timer overflows; timer 0 in mode 3 does not raise its flag.
	// Mode 3 blocks only the set, so a flag already up still waits.
	always_comb begin
		tf0_set = timer0_overflow;
		if (timer0_mode3) begin
			tf0_set = 1'b0;
		end
		tf1_set = timer1_overflow;
		tf2_set = timer2_overflow;
		exf2_set = pin_fall[`ISEL_PIN_T2X];
	end

	// Event-set flags for the two-wire bus, converter and USB groups.
	always_comb begin
		i2c_set = |twowire_events;
		adc_set = conversion_done;
		usb_glb_set = |usb_global_events;
		usb_in_set = |usb_in_empty;
		usb_out_set = |usb_out_full;
		usb_nak_set = |usb_in_nak;
	end

	always_comb begin
		flag_set = '0;
		flag_set[`ISEL_FLG_EXT0] = ext0_edge_set | ext0_level_set;
		flag_set[`ISEL_FLG_EXT1] = ext1_edge_set | ext1_level_set;
		flag_set[`ISEL_FLG_TF0] = tf0_set;
		flag_set[`ISEL_FLG_TF1] = tf1_set;
		flag_set[`ISEL_FLG_TF2] = tf2_set;
		flag_set[`ISEL_FLG_EXF2] = exf2_set;
		flag_set[`ISEL_FLG_I2C] = i2c_set;
		flag_set[`ISEL_FLG_ADC] = adc_set;
		flag_set[`ISEL_FLG_USB_GLB] = usb_glb_set;
		flag_set[`ISEL_FLG_USB_IN] = usb_in_set;
		flag_set[`ISEL_FLG_USB_OUT] = usb_out_set;
		flag_set[`ISEL_FLG_USB_NAK] = usb_nak_set;
	end

	// Only external inputs (edge on service, level on pin release), timers 0 and 1 and the two-wire flag self-clear.
	always_comb begin
		flag_hw_clr = '0;
		flag_hw_clr[`ISEL_FLG_EXT0] = ext0_svc_clr | ext0_level_clr;
		flag_hw_clr[`ISEL_FLG_EXT1] = ext1_svc_clr | ext1_level_clr;
		flag_hw_clr[`ISEL_FLG_TF0] = svc_enter[`ISEL_SRC_T0];
		flag_hw_clr[`ISEL_FLG_TF1] = svc_enter[`ISEL_SRC_T1];
		flag_hw_clr[`ISEL_FLG_I2C] = svc_enter[`ISEL_SRC_I2C];
	end

	// Software clears reach every flag; level-mode inputs ignore them
	// while the pin is still low, because the set wins.
	assign flag_clr = flag_hw_clr | flag_sw_clr;

	isel_flags #(
		.W(`ISEL_NFLG)
	) u_flags (
		.clk_sys (clk_sys),
		.rst     (rst),
		.set     (flag_set),
		.clr     (flag_clr),
		.flag_q  (flag_q)
	);

	// Combined source flags; sub-flags stay separate for software.
	// Serial, peripheral port and counter array flags live in their
	// owning blocks, so only their OR is formed here.
	always_comb begin
		ser0_any = serial0_rx_flag | serial0_tx_flag;
		ser1_any = serial1_rx_flag | serial1_tx_flag;
		t2_any = flag_q[`ISEL_FLG_TF2]
			| flag_q[`ISEL_FLG_EXF2];
		spi_any = |spi_flags;
		pca_any = |pca_flags;
		usb_any = flag_q[`ISEL_FLG_USB_GLB] | flag_q[`ISEL_FLG_USB_IN]
			| flag_q[`ISEL_FLG_USB_OUT]
			| flag_q[`ISEL_FLG_USB_NAK];
	end

	always_comb begin
		src_active = '0;
		src_active[`ISEL_SRC_EXT0] = flag_q[`ISEL_FLG_EXT0];
		src_active[`ISEL_SRC_T0] = flag_q[`ISEL_FLG_TF0];
		src_active[`ISEL_SRC_EXT1] = flag_q[`ISEL_FLG_EXT1];
		src_active[`ISEL_SRC_T1] = flag_q[`ISEL_FLG_TF1];
		src_active[`ISEL_SRC_SER0] = ser0_any;
		src_active[`ISEL_SRC_T2] = t2_any;
		src_active[`ISEL_SRC_SPI] = spi_any;
		src_active[`ISEL_SRC_USB] = usb_any;
		src_active[`ISEL_SRC_I2C] = flag_q[`ISEL_FLG_I2C];
		src_active[`ISEL_SRC_ADC] = flag_q[`ISEL_FLG_ADC];
		src_active[`ISEL_SRC_PCA] = pca_any;
		src_active[`ISEL_SRC_SER1] = ser1_any;
	end

	assign src_enable = enable_map(st_q.primary, st_q.extra);

	assign wr_primary = sfr_wr & addr_hit(sfr_addr, `ISEL_ADDR_PRIMARY);
	assign wr_extra = sfr_wr & addr_hit(sfr_addr, `ISEL_ADDR_EXTRA);

	always_comb begin
		st_d = st_q;
		if (wr_primary) begin
			// The tracing bit is stored like any other bit.
			st_d.primary = sfr_wdata;
		end
		if (wr_extra) begin
			// Reserved bits never store, so a stray one cannot stick.
			st_d.extra = sfr_wdata & `ISEL_IEA_WMASK;
		end
		st_d.rdata = `ISEL_RD_IDLE;
		if (sfr_rd) begin
			st_d.rdata = reg_read(sfr_addr, st_q.primary, st_q.extra);
		end
		// Rebuilt from live flags each cycle; a refused request is
		// not held, so a flag gone before the next poll is lost.
		st_d.req = gate_req(src_active, src_enable,
			st_q.primary[`ISEL_IE_GLOBAL]);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q.primary <= `ISEL_RST_PRIMARY;
			st_q.extra <= `ISEL_RST_EXTRA;
			st_q.rdata <= `ISEL_RD_IDLE;
			st_q.req <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sfr_rdata = st_q.rdata;
	assign irq_req = st_q.req;
	assign primary_irq_enable = st_q.primary;
	assign extra_irq_enable = st_q.extra;
endmodule

/* tb/isel_core_model.sv */
`timescale 1ns/1ns
module isel_core_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        poll_en,
	input  wire logic [3:0]  lag,
	input  wire logic [11:0] irq_req,
	output logic      [11:0] svc_enter
);
	logic [3:0] wait_q;
	// Each poll sees only the requests present now; a refused one is lost.
	// The pause after an entry lets the cleared flag reach the request.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			svc_enter <= 12'h000;
			wait_q    <= 4'h0;
		end else begin
			svc_enter <= 12'h000;
			if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (poll_en && irq_req != 12'h000) begin
				svc_enter <= irq_req & (~irq_req + 12'h001);
				wait_q    <= lag + 4'h3;
			end
		end
	end
endmodule

/* tb/isel_top_chk.sv */
`timescale 1ns/1ns
module isel_top_chk #(
	parameter int USB_EP = 10
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        timer0_overflow,
	input wire logic        timer0_mode3,
	input wire logic        timer1_overflow,
	input wire logic        serial0_rx_flag,
	input wire logic        serial0_tx_flag,
	input wire logic [7:0]  pca_flags,
	input wire logic [11:0] flag_sw_clr,
	input wire logic [11:0] flag_q,
	input wire logic [11:0] irq_req,
	input wire logic [7:0]  primary_irq_enable,
	input wire logic [7:0]  extra_irq_enable
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_global_blocks: assert property (!primary_irq_enable[7]
		|=> !irq_req)
		else $error("request passed with global enable low");
	a_t1_gate: assert property (irq_req[3] == $past(flag_q[3]
		& primary_irq_enable[7] & primary_irq_enable[3]))
		else $error("timer1 request gating wrong");
	a_ser0_gate: assert property (irq_req[4] == $past(
		(serial0_rx_flag | serial0_tx_flag)
		& primary_irq_enable[7] & primary_irq_enable[4]))
		else $error("serial0 request gating wrong");
	a_pca_gate: assert property (irq_req[10] == $past((|pca_flags)
		& primary_irq_enable[7] & extra_irq_enable[5]))
		else $error("counter array request gating wrong");
	a_t1_set: assert property (timer1_overflow |=> flag_q[3])
		else $error("timer1 overflow flag not set");
	a_t0_mode3: assert property (timer0_overflow && timer0_mode3
		&& !flag_q[2] |=> !flag_q[2])
		else $error("timer0 flag set in mode 3");
	a_adc_keep: assert property (flag_q[7] && !flag_sw_clr[7]
		|=> flag_q[7])
		else $error("conversion flag dropped without software clear");
	a_extra_rsvd: assert property (extra_irq_enable[3:2] == 2'b00)
		else $error("reserved enable bits stored");
	a_wr_primary: assert property (sfr_wr && sfr_addr == 8'ha8
		|=> primary_irq_enable == $past(sfr_wdata))
		else $error("primary enable write lost");
	a_rd_extra: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'ha7
		|=> sfr_rdata == $past(extra_irq_enable))
		else $error("extra enable read wrong");
endmodule
bind isel_top isel_top_chk #(.USB_EP(USB_EP)) u_chk (.clk_sys, .rst,
	.sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .timer0_overflow,
	.timer0_mode3, .timer1_overflow, .serial0_rx_flag, .serial0_tx_flag,
	.pca_flags, .flag_sw_clr, .flag_q, .irq_req, .primary_irq_enable,
	.extra_irq_enable);

/* tb/isel_top_test.sv */
`timescale 1ns/1ns
module isel_top_test;
	logic        clk_sys = 1'b0, rst = 1'b1, poll_en = 1'b0;
	logic [3:0]  lag = 4'h0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd, pe, xe;
	logic        sfr_wr = 1'b0, sfr_rd = 1'b0, timer0_mode3 = 1'b0;
	logic        ext_irq_pin_0 = 1'b1, ext_irq_pin_1 = 1'b1;
	logic        timer2_trigger_pin = 1'b1, conversion_done = 1'b0;
	logic        ext0_trigger_type = 1'b1, ext1_trigger_type = 1'b0;
	logic        timer0_overflow = 1'b0, timer1_overflow = 1'b0;
	logic        timer2_overflow = 1'b0;
	logic        serial0_rx_flag = 1'b0, serial0_tx_flag = 1'b0;
	logic        serial1_rx_flag = 1'b0, serial1_tx_flag = 1'b0;
	logic [3:0]  spi_flags = 4'h0, twowire_events = 4'h0;
	logic [3:0]  usb_global_events = 4'h0;
	logic [7:0]  pca_flags = 8'h00, primary_irq_enable, extra_irq_enable;
	logic [9:0]  usb_in_empty = 10'h000, usb_out_full = 10'h000;
	logic [9:0]  usb_in_nak = 10'h000;
	logic [11:0] flag_sw_clr = 12'h000, svc_enter, flag_q, irq_req;
	int          fails = 0, tests_run = 0;
	int          fb[15] = '{3, 4, 7, 6, 6, 6, 6, 8, 8, 8, 8, 9, 10, 11, 2};
	always #5 clk_sys = ~clk_sys;
	isel_top u_dut (.clk_sys, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_rdata, .ext_irq_pin_0, .ext_irq_pin_1, .timer2_trigger_pin,
		.ext0_trigger_type, .ext1_trigger_type, .timer0_overflow,
		.timer0_mode3, .timer1_overflow, .timer2_overflow, .serial0_rx_flag,
		.serial0_tx_flag, .serial1_rx_flag, .serial1_tx_flag, .spi_flags,
		.twowire_events, .conversion_done, .pca_flags, .usb_global_events,
		.usb_in_empty, .usb_out_full, .usb_in_nak, .svc_enter, .flag_sw_clr,
		.flag_q, .irq_req, .primary_irq_enable, .extra_irq_enable);
	isel_core_model u_core (.clk_sys, .rst, .poll_en, .lag, .irq_req,
		.svc_enter);
	task automatic stop_test();
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [11:0] e,
		input logic [11:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask
	task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		{sfr_rd, sfr_addr} = {1'b1, a};
		@(negedge clk_sys);
		d = sfr_rdata;
		sfr_rd = 1'b0;
	endtask
	task automatic wait_flag(input int b, input logic v, input int lim,
		input string n);
		for (int i = 0; i < lim && flag_q[b] !== v; i++) @(negedge clk_sys);
		chk(n, {11'h000, v}, {11'h000, flag_q[b]});
	endtask
	task automatic sw_clear();
		@(negedge clk_sys);
		flag_sw_clr = 12'hfff;
		@(negedge clk_sys);
		flag_sw_clr = 12'h000;
		@(negedge clk_sys);
	endtask
	task automatic pulse(input int k);
		int ep;
		ep = $urandom_range(9);
		@(negedge clk_sys);
		case (k)
			0: timer1_overflow = 1'b1;
			1: timer2_overflow = 1'b1;
			2: conversion_done = 1'b1;
			3, 4, 5, 6: twowire_events[k - 3] = 1'b1;
			7, 8, 9, 10: usb_global_events[k - 7] = 1'b1;
			11: usb_in_empty[ep] = 1'b1;
			12: usb_out_full[ep] = 1'b1;
			13: usb_in_nak[ep] = 1'b1;
			default: timer0_overflow = 1'b1;
		endcase
		@(negedge clk_sys);
		{timer0_overflow, timer1_overflow, timer2_overflow} = 3'h0;
		{conversion_done, twowire_events, usb_global_events} = 9'h000;
		{usb_in_empty, usb_out_full, usb_in_nak} = 30'h0;
	endtask
	function automatic logic [11:0] exp_lvl(input logic [7:0] p,
		input logic [7:0] x);
		logic [11:0] r;
		r = 12'h000;
		r[4] = (serial0_rx_flag | serial0_tx_flag) & p[4];
		r[6] = (|spi_flags) & x[6];
		r[10] = (|pca_flags) & x[5];
		r[11] = (serial1_rx_flag | serial1_tx_flag) & x[4];
		return p[7] ? r : 12'h000;
	endfunction
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h84e7));
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		sfr_r(8'ha8, rd);
		chk("primary reset", 12'h000, {4'h0, rd});
		sfr_r(8'ha7, rd);
		chk("extra reset", 12'h000, {4'h0, rd});
		sfr_w(8'h55, 8'hff);
		sfr_r(8'h55, rd);
		chk("unmapped read", 12'h000, {4'h0, rd});
		for (int i = 0; i < 24; i++) begin
			pe = (i == 0) ? 8'h7f : 8'($urandom);
			sfr_r(8'ha8, rd);
			pe[6] = rd[6];
			xe = (i == 0) ? 8'hff : 8'($urandom);
			sfr_w(8'ha8, pe);
			sfr_w(8'ha7, xe);
			{serial0_rx_flag, serial0_tx_flag} = 2'($urandom);
			{serial1_rx_flag, serial1_tx_flag} = 2'($urandom);
			spi_flags = (i == 0) ? 4'hf : 4'($urandom);
			pca_flags = (i == 0) ? 8'hff : 8'($urandom);
			sfr_r(8'ha8, rd);
			chk("primary", {4'h0, pe}, {4'h0, rd});
			sfr_r(8'ha7, rd);
			chk("extra", {4'h0, xe & 8'hf3}, {4'h0, rd});
			chk("level req", exp_lvl(pe, xe), irq_req);
		end
		{serial0_rx_flag, serial1_rx_flag, spi_flags, pca_flags} = 14'h0;
		timer0_mode3 = 1'b1;
		pulse(14);
		chk("t0 mode3", 12'h000, flag_q);
		timer0_mode3 = 1'b0;
		for (int k = 0; k < 15; k++) begin
			pulse(k);
			chk("event flag", 12'h001 << fb[k], flag_q);
			sw_clear();
			chk("flag clear", 12'h000, flag_q);
		end
		sfr_w(8'ha8, 8'hbf);
		sfr_w(8'ha7, 8'hf3);
		{serial0_tx_flag, serial1_tx_flag} = 2'b00;
		poll_en = 1'b1;
		lag = 4'($urandom_range(3));
		ext_irq_pin_0 = 1'b0;
		wait_flag(0, 1'b1, 8, "ext0 edge set");
		wait_flag(0, 1'b0, 12, "ext0 svc clear");
		ext_irq_pin_0 = 1'b1;
		ext_irq_pin_1 = 1'b0;
		wait_flag(1, 1'b1, 8, "ext1 level set");
		repeat (12) @(negedge clk_sys);
		chk("ext1 level held", 12'h004, irq_req);
		ext_irq_pin_1 = 1'b1;
		wait_flag(1, 1'b0, 10, "ext1 level drop");
		pulse(0);
		wait_flag(3, 1'b0, 16, "t1 svc clear");
		pulse(3);
		wait_flag(6, 1'b0, 16, "i2c svc clear");
		pulse(2);
		repeat (12) @(negedge clk_sys);
		chk("adc kept", 12'h080, flag_q);
		sw_clear();
		poll_en = 1'b0;
		timer2_trigger_pin = 1'b0;
		wait_flag(5, 1'b1, 8, "t2 pin flag");
		repeat (2) @(negedge clk_sys);
		chk("t2 request", 12'h020, irq_req);
		sw_clear();
		stop_test();
	end
endmodule
